// ### ccif_comparator_control.sv
// Contract
// - Enable bit 10 switches comparator on.
// - Bits 9:8 select the negative reference.
// - Bits 7:6 route result to pin or interrupt.
// - Bit 5 inverts the output polarity.
// - Bits 4:3 forward response time to analog.
// - Bit 2 turns on hysteresis.
// - Rising edge sets bit 1; write one clears.
// - Falling edge sets bit 0 until cleared.
// - Sixteen-bit register, zero after reset, 15:11 reserved.
// - Result reaches interrupt, logic array, converter, pin.
//
// Purpose: Control and status wrapper around the analog comparator.
// Assumes: Classic Wishbone slave; raw result is asynchronous.
// Notes:   Ack comes one cycle after the request is seen.

`timescale 1ns/100ps

module ccif_comparator_control (
   input  wire logic                        clock,
   input  wire logic                        reset,
   input  wire logic                        cyc_i,
   input  wire logic                        stb_i,
   input  wire logic                        we_i,
   input  wire logic [ccif_pkg::WB_AW-1:0]  adr_i,
   input  wire logic [ccif_pkg::WB_SW-1:0]  sel_i,
   input  wire logic [ccif_pkg::WB_DW-1:0]  dat_i,
   output logic      [ccif_pkg::WB_DW-1:0]  dat_o,
   output logic                             ack_o,
   input  wire logic                        compRawResult,
   output logic                             compEnable,
   output logic      [1:0]                  negInputSelect,
   output logic      [1:0]                  responseTimeSelect,
   output logic                             hysteresisEnable,
   output logic                             compResultPin,
   output logic                             plaCompResult,
   output logic                             adcTrigger,
   output logic                             irq
);
   import ccif_pkg::*;

   // ------------------------------------------------------------------
   // State and submodules
   // ------------------------------------------------------------------
   ccif_top_s             state_r;
   ccif_top_s             state_nxt;
   logic                  syncResult;
   logic                  monitored;
   logic                  riseEvent;
   logic                  fallEvent;
   logic                  riseClear;
   logic                  fallClear;
   logic                  request;
   logic                  hitCtrl;
   logic                  hitMask;
   logic                  writeLow;
   logic                  writeHigh;
   logic                  analogChange;
   logic [CTRL_W-1:0]     ctrlView;

   ccif_flag_if riseIf ();
   ccif_flag_if fallIf ();

   // The raw comparator output has no relation to clock.
   ccif_sync u_sync (
      .clock   (clock),
      .reset   (reset),
      .asyncIn (compRawResult),
      .syncOut (syncResult)
   );

   ccif_flag u_rise (
      .clock    (clock),
      .reset    (reset),
      .flagPort (riseIf.keeper)
   );

   ccif_flag u_fall (
      .clock    (clock),
      .reset    (reset),
      .flagPort (fallIf.keeper)
   );

   assign riseIf.setEvent = riseEvent;
   assign riseIf.clearReq = riseClear;
   assign fallIf.setEvent = fallEvent;
   assign fallIf.clearReq = fallClear;

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   always_comb begin
      request   = cyc_i & stb_i & ~state_r.ack;
      hitCtrl   = adr_i[WB_AW-1:WORD_LSB] == ADDR_CTRL[WB_AW-1:WORD_LSB];
      hitMask   = adr_i[WB_AW-1:WORD_LSB] == ADDR_MASK[WB_AW-1:WORD_LSB];
      writeLow  = request & we_i & sel_i[LANE_LOW];
      writeHigh = request & we_i & sel_i[LANE_HIGH];
      // Writing zero to a flag leaves it alone.
      riseClear = writeLow & hitCtrl & dat_i[BIT_RISE];
      fallClear = writeLow & hitCtrl & dat_i[BIT_FALL];
   end

   // ------------------------------------------------------------------
   // Control register view
   // ------------------------------------------------------------------
   always_comb begin
      ctrlView                    = '0;
      ctrlView[BIT_ENABLE]        = state_r.en;
      ctrlView[NEG_HI:NEG_LO]     = state_r.negSel;
      ctrlView[ROUTE_HI:ROUTE_LO] = state_r.route;
      ctrlView[BIT_POL]           = state_r.pol;
      ctrlView[RES_HI:RES_LO]     = state_r.resSel;
      ctrlView[BIT_HYST]          = state_r.hyst;
      ctrlView[BIT_RISE]          = riseIf.flag;
      ctrlView[BIT_FALL]          = fallIf.flag;
   end

   // ------------------------------------------------------------------
   // Result monitoring
   // ------------------------------------------------------------------
   always_comb begin
      // A disabled comparator reads low; its only edge is the fall when it is switched off while high.
      monitored = state_r.en & (syncResult ^ state_r.pol);
      // Edges are ignored while the analog side settles after a change.
      riseEvent = monitored & ~state_r.prevMon &
                  (state_r.settle == '0);
      fallEvent = ~monitored & state_r.prevMon &
                  (state_r.settle == '0);
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt     = state_r;
      state_nxt.ack = request;

      if (writeHigh & hitCtrl) begin
         state_nxt.en     = dat_i[BIT_ENABLE];
         state_nxt.negSel = dat_i[NEG_HI:NEG_LO];
      end
      if (writeLow & hitCtrl) begin
         state_nxt.route  = dat_i[ROUTE_HI:ROUTE_LO];
         state_nxt.pol    = dat_i[BIT_POL];
         state_nxt.resSel = dat_i[RES_HI:RES_LO];
         state_nxt.hyst   = dat_i[BIT_HYST];
      end
      if (writeLow & hitMask) begin
         state_nxt.mask = dat_i[BIT_RISE:BIT_FALL];
      end

      // Unmapped addresses answer with zero and store nothing.
      if (request & ~we_i) begin
         if (hitCtrl) begin
            state_nxt.rdata = {{(WB_DW-CTRL_W){1'b0}}, ctrlView};
         end else if (hitMask) begin
            state_nxt.rdata = {{(WB_DW-2){1'b0}}, state_r.mask};
         end else begin
            state_nxt.rdata = '0;
         end
      end

      // Any change of the analog setup that leaves the comparator on restarts the blanking time,
      // trading a short blind spot for freedom from false edges.
      analogChange = (state_nxt.en & ~state_r.en) |
                     (state_nxt.negSel != state_r.negSel) |
                     (state_nxt.resSel != state_r.resSel) |
                     (state_nxt.hyst != state_r.hyst) |
                     (state_nxt.pol != state_r.pol);
      if (state_nxt.en & analogChange) begin
         if (state_nxt.resSel == RES_FAST) begin
            state_nxt.settle = SETTLE_FAST_CYC;
         end else begin
            state_nxt.settle = SETTLE_SLOW_CYC;
         end
      end else if (state_r.settle != '0) begin
         state_nxt.settle = state_r.settle - ccif_count_t'(1);
      end

      state_nxt.prevMon = monitored;

      // The four destinations of the result.
      state_nxt.pin     = monitored &
                          (state_r.route == ROUTE_PIN);
      state_nxt.programmable_logic_array     = monitored;
      state_nxt.adcTrig = riseEvent;
      state_nxt.irq     = (state_r.route == ROUTE_IRQ) &
                          ((riseIf.flag & state_r.mask[BIT_RISE]) |
                           (fallIf.flag & state_r.mask[BIT_FALL]));
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= TOP_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign dat_o              = state_r.rdata;
   assign ack_o              = state_r.ack;
   assign compEnable         = state_r.en;
   assign negInputSelect     = state_r.negSel;
   assign responseTimeSelect = state_r.resSel;
   assign hysteresisEnable   = state_r.hyst;
   assign compResultPin      = state_r.pin;
   assign plaCompResult      = state_r.programmable_logic_array;
   assign adcTrigger         = state_r.adcTrig;
   assign irq                = state_r.irq;
endmodule

// ### ccif_pkg.sv
// Purpose: Shared constants and state types of the comparator control block.
// Assumes: Classic Wishbone with 32-bit data and byte addresses.
// Notes:   Each register takes one aligned word; narrow data sits low.

package ccif_pkg;

   // ------------------------------------------------------------------
   // Bus and register map
   // ------------------------------------------------------------------
   localparam int unsigned WB_AW     = 32;
   localparam int unsigned WB_DW     = 32;
   localparam int unsigned WB_SW     = 4;
   localparam int unsigned CTRL_W    = 16;
   localparam logic [31:0] ADDR_CTRL = 32'hffff0444;
   localparam logic [31:0] ADDR_MASK = 32'hffff0448;
   localparam int unsigned WORD_LSB  = 2;

   // ------------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------------
   localparam int unsigned BIT_ENABLE = 10;
   localparam int unsigned NEG_HI     = 9;
   localparam int unsigned NEG_LO     = 8;
   localparam int unsigned ROUTE_HI   = 7;
   localparam int unsigned ROUTE_LO   = 6;
   localparam int unsigned BIT_POL    = 5;
   localparam int unsigned RES_HI     = 4;
   localparam int unsigned RES_LO     = 3;
   localparam int unsigned BIT_HYST   = 2;
   localparam int unsigned BIT_RISE   = 1;
   localparam int unsigned BIT_FALL   = 0;
   localparam int unsigned LANE_LOW   = 0;
   localparam int unsigned LANE_HIGH  = 1;

   // ------------------------------------------------------------------
   // Field codes
   // ------------------------------------------------------------------
   localparam logic [1:0] NEG_HALF_SUPPLY = 2'h0;
   localparam logic [1:0] NEG_CONV_INPUT3 = 2'h1;
   localparam logic [1:0] NEG_DAC_OUT0    = 2'h2;
   localparam logic [1:0] ROUTE_PIN       = 2'h2;
   localparam logic [1:0] ROUTE_IRQ       = 2'h3;
   localparam logic [1:0] RES_SLOW        = 2'h0;
   localparam logic [1:0] RES_FAST        = 2'h3;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned SETTLE_SLOW_NS = 17000;
   localparam int unsigned SETTLE_FAST_NS = 3000;
   typedef logic [9:0] ccif_count_t;
   localparam ccif_count_t SETTLE_SLOW_CYC = ccif_count_t'(
      (SETTLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam ccif_count_t SETTLE_FAST_CYC = ccif_count_t'(
      (SETTLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ------------------------------------------------------------------
   // State types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic              ack;
      logic [WB_DW-1:0]  rdata;
      logic              en;
      logic [1:0]        negSel;
      logic [1:0]        route;
      logic              pol;
      logic [1:0]        resSel;
      logic              hyst;
      logic [1:0]        mask;
      logic              prevMon;
      ccif_count_t       settle;
      logic              pin;
      logic              programmable_logic_array;
      logic              adcTrig;
      logic              irq;
   } ccif_top_s;

   typedef struct packed {
      logic stage1;
      logic stage2;
   } ccif_sync_s;

   typedef struct packed {
      logic flag;
   } ccif_flag_s;

   localparam ccif_top_s  TOP_RESET  = '0;
   localparam ccif_sync_s SYNC_RESET = '0;
   localparam ccif_flag_s FLAG_RESET = '0;

endpackage

// ### ccif_flag_if.sv
// Purpose: Carries one sticky event flag between the top and its keeper.
// Assumes: One clock domain.
// Notes:   Set and clear may arrive in the same cycle.

`timescale 1ns/100ps

interface ccif_flag_if;
   logic setEvent;
   logic clearReq;
   logic flag;

   modport keeper (
      input  setEvent,
      input  clearReq,
      output flag
   );

   modport user (
      output setEvent,
      output clearReq,
      input  flag
   );
endinterface

// ### ccif_sync.sv
// Purpose: Two-stage synchroniser for the analog comparator result.
// Assumes: The input may change at any time relative to clock.
// Notes:   Only the second stage is visible outside.

`timescale 1ns/100ps

module ccif_sync (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic asyncIn,
   output logic      syncOut
);
   import ccif_pkg::*;

   ccif_sync_s state_r;
   ccif_sync_s state_nxt;

   always_comb begin
      state_nxt        = state_r;
      state_nxt.stage1 = asyncIn;
      state_nxt.stage2 = state_r.stage1;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= SYNC_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign syncOut = state_r.stage2;
endmodule

// ### ccif_flag.sv
// Purpose: One sticky event flag, set by hardware, cleared by software.
// Assumes: Clear requests are single-cycle pulses.
// Notes:   A set in the clearing cycle keeps the flag high.

`timescale 1ns/100ps

module ccif_flag (
   input  wire logic    clock,
   input  wire logic    reset,
   ccif_flag_if.keeper  flagPort
);
   import ccif_pkg::*;

   ccif_flag_s state_r;
   ccif_flag_s state_nxt;

   always_comb begin
      state_nxt      = state_r;
      state_nxt.flag = flagPort.setEvent |
                       (state_r.flag & ~flagPort.clearReq);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= FLAG_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign flagPort.flag = state_r.flag;
endmodule

// ### ccif_comparator_control_asserts.sv
// Purpose: Port-level checks of the comparator control block.
// Assumes: Sees only top ports; one clock domain.
// Notes:   Bound from the testbench top file.

`timescale 1ns/100ps

module ccif_comparator_control_asserts (
   input wire logic                       clock,
   input wire logic                       reset,
   input wire logic                       cyc_i,
   input wire logic                       stb_i,
   input wire logic                       we_i,
   input wire logic [ccif_pkg::WB_AW-1:0] adr_i,
   input wire logic [ccif_pkg::WB_SW-1:0] sel_i,
   input wire logic [ccif_pkg::WB_DW-1:0] dat_i,
   input wire logic [ccif_pkg::WB_DW-1:0] dat_o,
   input wire logic                       ack_o,
   input wire logic                       compEnable,
   input wire logic [1:0]                 negInputSelect,
   input wire logic [1:0]                 responseTimeSelect,
   input wire logic                       hysteresisEnable,
   input wire logic                       compResultPin,
   input wire logic                       plaCompResult,
   input wire logic                       adcTrigger
);
   import ccif_pkg::*;
   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_ctrlWr;
      s_take ##0 (we_i && adr_i == ADDR_CTRL);
   endsequence
   a_ack_after_take: assert property (s_take |=> ack_o)
      else $error("ack missing after a request");
   a_ack_single_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_no_request: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without a request");
   a_ctrl_high_lane: assert property ((s_ctrlWr ##0 sel_i[LANE_HIGH]) |=>
      compEnable == $past(dat_i[BIT_ENABLE]) &&
      negInputSelect == $past(dat_i[NEG_HI:NEG_LO]))
      else $error("enable or input select not taken");
   a_ctrl_low_lane: assert property ((s_ctrlWr ##0 sel_i[LANE_LOW]) |=>
      responseTimeSelect == $past(dat_i[RES_HI:RES_LO]) &&
      hysteresisEnable == $past(dat_i[BIT_HYST]))
      else $error("response or hysteresis not taken");
   a_read_reserved: assert property (ack_o |->
      dat_o[WB_DW-1:BIT_ENABLE+1] == '0)
      else $error("reserved read bits not zero");
   a_off_no_result: assert property (!compEnable |=> !plaCompResult)
      else $error("result seen while disabled");
   a_pin_from_result: assert property (compResultPin |-> plaCompResult)
      else $error("pin high without result");
   a_trig_on_rise: assert property (adcTrigger |->
      plaCompResult && !$past(plaCompResult))
      else $error("trigger without rising result");
endmodule

// ### ccif_analog_model.sv
// Purpose: Behavioural analog comparator facing the control block.
// Assumes: level is the commanded sign of positive minus negative.
// Notes:   Output is asynchronous to the bus clock.

`timescale 1ns/100ps

module ccif_analog_model (
   input wire logic       level,
   input wire logic       compEnable,
   input wire logic [1:0] responseTimeSelect,
   output logic           compRawResult
);
   initial compRawResult = 1'b0;
   // Faster code settles sooner; the exact figures are arbitrary.
   always @(level or compEnable) begin
      compRawResult <= #(responseTimeSelect == 2'h3 ? 73 : 131) level;
   end
   // A powered-down comparator gives no trustworthy level.
   always #37 if (!compEnable) compRawResult = ~compRawResult;
endmodule

// ### test_comparator_control_interface.sv
// Purpose: Self-checking bench of the comparator control block.
// Assumes: Settle blanking of 120 cycles with the fast response code.
// Notes:   Random field values from a fixed seed.

`timescale 1ns/100ps

bind ccif_comparator_control ccif_comparator_control_asserts
   ccif_comparator_control_asserts_inst (.clock(clock), .reset(reset),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .compEnable(compEnable), .negInputSelect(negInputSelect),
   .responseTimeSelect(responseTimeSelect),
   .hysteresisEnable(hysteresisEnable), .compResultPin(compResultPin),
   .plaCompResult(plaCompResult), .adcTrigger(adcTrigger));

module test_comparator_control_interface;
   import ccif_pkg::*;
   logic        clock, reset, cyc, stb, we, level, raw, en, hyst;
   logic        pin, programmable_logic_array, trig, irq, ack;
   logic [1:0]  neg, res;
   logic [3:0]  sel;
   logic [31:0] adr, wdat, rdat, rd, v;
   int          error_cnt, comparisons, seed, trigCnt;

   always #12.5 clock = ~clock;

   // Every converter trigger pulse is counted so that lost or extra
   // pulses show up, not only pulses without a rising result.
   always @(posedge clock) if (trig === 1'b1) trigCnt <= trigCnt + 1;

   ccif_comparator_control ccif_comparator_control_inst (
      .clock(clock), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .compRawResult(raw), .compEnable(en), .negInputSelect(neg),
      .responseTimeSelect(res), .hysteresisEnable(hyst),
      .compResultPin(pin), .plaCompResult(programmable_logic_array), .adcTrigger(trig),
      .irq(irq));
   ccif_analog_model ccif_analog_model_inst (.level(level),
      .compEnable(en), .responseTimeSelect(res), .compRawResult(raw));

   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The request stands until ack is sampled high; only the watchdog
   // ends a wait that never gets an answer.
   task automatic wb(input logic w, input logic [31:0] a, d);
      @(posedge clock);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do begin
         @(posedge clock);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic flags(input logic [1:0] exp);
      repeat (10) @(posedge clock);
      wb(1'b0, ADDR_CTRL, 32'h0);
      check("flags", 32'(rd[1:0]), 32'(exp));
   endtask

   function automatic logic [31:0] cfg(input logic e, input logic [1:0] n,
      input logic [1:0] r, input logic p, input logic [1:0] t,
      input logic h);
      return {21'h0, e, n, r, p, t, h, 2'h0};
   endfunction

   task summarize;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      summarize;
   end

   initial begin
      clock = 0; reset = 1; cyc = 0; stb = 0; we = 0; adr = '0;
      sel = '0; wdat = '0; level = 0; seed = 64;
      error_cnt = 0; comparisons = 0;
      trigCnt = 0;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      wb(1'b0, ADDR_CTRL, 32'h0); check("ctrl reset", rd, 32'h0);
      wb(1'b0, ADDR_MASK, 32'h0); check("mask reset", rd, 32'h0);
      wb(1'b1, 32'hffff0450, 32'hffff);
      wb(1'b0, 32'hffff0450, 32'h0); check("unmapped", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = cfg(1'b0, 2'(i), 2'($random(seed)), 1'($random(seed)),
                 2'($random(seed)), 1'($random(seed)));
         wb(1'b1, ADDR_CTRL, v | 32'hfffff803);
         wb(1'b0, ADDR_CTRL, 32'h0); check("readback", rd, v);
         check("neg", 32'(neg), 32'(i));
         check("res", 32'(res), 32'(v[RES_HI:RES_LO]));
         check("hyst", 32'(hyst), 32'(v[BIT_HYST]));
         check("en off", 32'(en), 32'h0);
      end
      wb(1'b1, ADDR_MASK, 32'h3);
      v = cfg(1'b1, NEG_HALF_SUPPLY, ROUTE_IRQ, 1'b0, RES_FAST, 1'b0);
      wb(1'b1, ADDR_CTRL, v); check("en on", 32'(en), 32'h1);
      repeat (130) @(posedge clock);
      level <= 1'b1; flags(2'b10);
      check("pla", 32'(programmable_logic_array), 32'h1);
      check("irq rise", 32'(irq), 32'h1); check("pin", 32'(pin), 32'h0);
      wb(1'b1, ADDR_CTRL, v | 32'h1); flags(2'b10);
      wb(1'b1, ADDR_CTRL, v | 32'h2); flags(2'b00);
      check("irq clear", 32'(irq), 32'h0);
      level <= 1'b0; flags(2'b01);
      check("irq fall", 32'(irq), 32'h1);
      wb(1'b1, ADDR_CTRL, v | 32'h1); flags(2'b00);
      wb(1'b1, ADDR_MASK, 32'h0);
      level <= 1'b1; flags(2'b10);
      check("irq masked", 32'(irq), 32'h0);
      v = cfg(1'b1, NEG_HALF_SUPPLY, ROUTE_PIN, 1'b0, RES_FAST, 1'b0);
      wb(1'b1, ADDR_CTRL, v | 32'h3); flags(2'b00);
      check("pin high", 32'(pin), 32'h1);
      v = cfg(1'b1, NEG_HALF_SUPPLY, ROUTE_PIN, 1'b1, RES_FAST, 1'b0);
      wb(1'b1, ADDR_CTRL, v | 32'h3); repeat (130) @(posedge clock);
      check("pin inverted", 32'(pin), 32'h0);
      level <= 1'b0; flags(2'b10);
      check("pin below", 32'(pin), 32'h1);
      // The slow response code blanks edges for the longer settle time.
      v = cfg(1'b1, NEG_HALF_SUPPLY, ROUTE_PIN, 1'b1, RES_SLOW, 1'b0);
      wb(1'b1, ADDR_CTRL, v | 32'h3);
      level <= 1'b1;
      flags(2'b00);
      repeat (700) @(posedge clock);
      level <= 1'b0;
      flags(2'b10);
      wb(1'b1, ADDR_CTRL, 32'h0); repeat (4) @(posedge clock);
      check("pla off", 32'(programmable_logic_array), 32'h0);
      // Switching off while the result is high is a falling edge.
      flags(2'b11);
      check("trigger count", 32'(trigCnt), 32'h4);
      summarize;
   end
endmodule
